// File: hdl/actip_pkg.sv
// Function
// - inputs sampled on link rising edge, enable low
// - almost-full flag changes on link rising edges
// - one 8-bit byte per accepted edge
// - flag low when five bytes of space remain
// - flag high when a whole cell fits
// - device reset high discards all stored cells
`default_nettype none
package actip_pkg;
	// cell geometry
	localparam int ACTIP_BYTE_W = 8; // width of one cell byte
	localparam int ACTIP_CELL_BYTES = 53; // bytes in one cell
	localparam int ACTIP_FIFO_CELLS = 3; // whole cells the fifo holds
	// almost-full hysteresis, counted in free bytes
	localparam int ACTIP_AF_SET_FREE = 5; // flag drops at this much space
	localparam int ACTIP_AF_CLR_FREE = 53; // flag rises at this much space
	// reset values
	localparam logic ACTIP_AF_N_RST = 1'h1; // flag inactive after reset
	localparam int ACTIP_SYNC_STAGES = 3; // pin synchroniser depth
endpackage
`default_nettype wire

// File: hdl/actip_tx_port.sv
`default_nettype none
module actip_tx_port
	import actip_pkg::*;
#(
	parameter int DEPTH = ACTIP_FIFO_CELLS * ACTIP_CELL_BYTES, // fifo bytes
	parameter int AF_SET_FREE = ACTIP_AF_SET_FREE, // low threshold
	parameter int AF_CLR_FREE = ACTIP_AF_CLR_FREE // high threshold
) (
	input wire logic clk_sys, // system clock, 100 MHz
	input wire logic rst_n, // async reset, active low
	input wire logic tx_port_clk, // writer's port clock pin
	input wire logic [ACTIP_BYTE_W-1:0] tx_cell_byte, // cell byte pin bus
	input wire logic tx_write_en_n, // write enable pin, active low
	input wire logic tx_start_of_cell, // first-byte marker pin
	input wire logic tx_dev_reset, // device reset pin, active high
	output logic tx_fifo_almost_full_n, // almost-full flag, active low
	output logic [ACTIP_BYTE_W-1:0] out_byte, // byte toward the mapper
	output logic out_soc, // marker travelling with out_byte
	output logic out_valid, // out_byte holds a byte
	input wire logic out_ready // mapper takes the byte
);
	localparam int PW = $clog2(DEPTH + 1); // pointer and count width
	localparam int IW = ACTIP_BYTE_W + 4; // byte plus marker, enable, clock, reset
	localparam logic [PW-1:0] LAST = PW'(DEPTH - 1); // last slot index
	localparam logic [PW-1:0] FULL = PW'(DEPTH); // count when full
	localparam logic [PW-1:0] SET_LVL = PW'(DEPTH - AF_SET_FREE); // drop level
	localparam logic [PW-1:0] CLR_LVL = PW'(DEPTH - AF_CLR_FREE); // rise level

	////////////////////////////////////////////////////////////////////////
	// pin synchronisers
	logic [IW-1:0] pin_s1_reg; // first stage, read only by stage two
	logic [IW-1:0] pin_s2_reg; // second stage
	logic [IW-1:0] pin_s3_reg; // third stage
	logic clk_lvl_reg; // filtered level of the port clock
	logic rst_lvl_reg; // filtered level of the device reset
	logic [IW-1:0] pin_bundle; // raw pins gathered together
	logic link_rise; // one-cycle pulse per port clock rising edge
	logic flush; // device reset holds the fifo empty

	assign pin_bundle = {tx_dev_reset, tx_port_clk, tx_write_en_n, tx_start_of_cell,
		tx_cell_byte};

	// three flops on every pin; data travels alongside the clock so the
	// sampled byte keeps its setup relation to the edge
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			pin_s1_reg <= '0;
			pin_s2_reg <= '0;
			pin_s3_reg <= '0;
		end else begin
			pin_s1_reg <= pin_bundle;
			pin_s2_reg <= pin_s1_reg;
			pin_s3_reg <= pin_s2_reg;
		end
	end

	// a level only changes once stages two and three agree
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			clk_lvl_reg <= 1'h0;
			rst_lvl_reg <= 1'h0;
		end else begin
			if (pin_s2_reg[IW-2] == pin_s3_reg[IW-2]) begin
				clk_lvl_reg <= pin_s3_reg[IW-2];
			end
			if (pin_s2_reg[IW-1] == pin_s3_reg[IW-1]) begin
				rst_lvl_reg <= pin_s3_reg[IW-1];
			end
		end
	end

	assign link_rise = !clk_lvl_reg && pin_s2_reg[IW-2] && pin_s3_reg[IW-2];
	assign flush = rst_lvl_reg;

	////////////////////////////////////////////////////////////////////////
	// write acceptance
	logic wr_en_n_s; // synchronised enable
	logic wr_soc_s; // synchronised marker
	logic [ACTIP_BYTE_W-1:0] wr_byte_s; // synchronised byte
	logic wr_take; // byte accepted this cycle
	logic rd_take; // byte leaves the store this cycle
	logic [PW-1:0] cnt_reg; // bytes held in the store

	assign wr_en_n_s = pin_s3_reg[IW-3];
	assign wr_soc_s = pin_s3_reg[ACTIP_BYTE_W];
	assign wr_byte_s = pin_s3_reg[ACTIP_BYTE_W-1:0];
	// a byte is taken only on a port clock edge with enable low; a byte
	// arriving while full is lost, the flag exists so that never happens
	assign wr_take = link_rise && !wr_en_n_s && !flush && (cnt_reg != FULL);

	////////////////////////////////////////////////////////////////////////
	// byte store
	logic [ACTIP_BYTE_W:0] mem_reg [DEPTH]; // marker and byte per slot
	logic [PW-1:0] wr_ptr_reg; // next slot to write
	logic [PW-1:0] rd_ptr_reg; // next slot to read
	logic [PW-1:0] cnt_next; // count after this cycle

	// one slot written per accepted edge, marker kept with its byte
	always_ff @(posedge clk_sys) begin
		if (wr_take) begin
			mem_reg[wr_ptr_reg] <= {wr_soc_s, wr_byte_s};
		end
	end

	// pointers wrap at the depth, which need not be a power of two
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else if (flush) begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else begin
			if (wr_take) begin
				wr_ptr_reg <= (wr_ptr_reg == LAST) ? '0 : wr_ptr_reg + 1'h1;
			end
			if (rd_take) begin
				rd_ptr_reg <= (rd_ptr_reg == LAST) ? '0 : rd_ptr_reg + 1'h1;
			end
		end
	end

	// count follows both sides; a flush empties it in one cycle
	always_comb begin
		cnt_next = cnt_reg;
		if (flush) begin
			cnt_next = '0;
		end else if (wr_take && !rd_take) begin
			cnt_next = cnt_reg + 1'h1;
		end else if (rd_take && !wr_take) begin
			cnt_next = cnt_reg - 1'h1;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			cnt_reg <= '0;
		end else begin
			cnt_reg <= cnt_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// output stage toward the cell mapper
	logic [ACTIP_BYTE_W-1:0] out_byte_reg; // presented byte
	logic out_soc_reg; // presented marker
	logic out_valid_reg; // presented byte is real

	// refill whenever the stage is empty or being drained
	assign rd_take = !flush && (cnt_reg != '0) && (!out_valid_reg || out_ready);

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			out_byte_reg <= '0;
			out_soc_reg <= 1'h0;
			out_valid_reg <= 1'h0;
		end else if (flush) begin
			out_valid_reg <= 1'h0;
			out_soc_reg <= 1'h0;
		end else if (rd_take) begin
			{out_soc_reg, out_byte_reg} <= mem_reg[rd_ptr_reg];
			out_valid_reg <= 1'h1;
		end else if (out_ready) begin
			out_valid_reg <= 1'h0;
		end
	end

	assign out_byte = out_byte_reg;
	assign out_soc = out_soc_reg;
	assign out_valid = out_valid_reg;

	////////////////////////////////////////////////////////////////////////
	// almost-full flag with hysteresis between the two thresholds;
	// it moves only on port clock edges so the writer sees it in its own
	// timing, at the cost of lagging a mapper read by up to one edge
	logic af_n_reg; // flag, active low

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			af_n_reg <= ACTIP_AF_N_RST;
		end else if (link_rise) begin
			if (cnt_next >= SET_LVL) begin
				af_n_reg <= 1'h0;
			end else if (cnt_next <= CLR_LVL) begin
				af_n_reg <= 1'h1;
			end
		end
	end

	assign tx_fifo_almost_full_n = af_n_reg;

	////////////////////////////////////////////////////////////////////////
	// checks
	sequence s_edge_near_full;
		link_rise && (cnt_next >= SET_LVL);
	endsequence

	sequence s_edge_room;
		link_rise && (cnt_next <= CLR_LVL);
	endsequence

	a_af_drop: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_edge_near_full |=> !tx_fifo_almost_full_n)
		else $error("flag not low with five bytes of space left");

	a_af_rise: assert property (@(posedge clk_sys) disable iff (!rst_n)
		s_edge_room |=> tx_fifo_almost_full_n)
		else $error("flag not high with room for a cell");

	a_af_edge_only: assert property (@(posedge clk_sys) disable iff (!rst_n)
		!$stable(tx_fifo_almost_full_n) |-> $past(link_rise))
		else $error("flag moved away from a port clock edge");

	a_write_gate: assert property (@(posedge clk_sys) disable iff (!rst_n)
		(cnt_reg == $past(cnt_reg) + 1'h1) |-> $past(link_rise && !wr_en_n_s))
		else $error("byte stored without enabled edge");

	a_byte_store: assert property (@(posedge clk_sys) disable iff (!rst_n)
		wr_take |=> (mem_reg[$past(wr_ptr_reg)] == $past({wr_soc_s, wr_byte_s})))
		else $error("stored byte differs from sampled byte");

	a_flush_empty: assert property (@(posedge clk_sys) disable iff (!rst_n)
		flush |=> (cnt_reg == '0) && !out_valid ##1 (!flush || cnt_reg == '0))
		else $error("device reset left bytes in the fifo");

endmodule
`default_nettype wire

// File: test/actip_cell_writer.sv
`default_nettype none
module actip_cell_writer
	import actip_pkg::*;
(
	output logic tx_port_clk, // link clock, still between frames
	output logic [ACTIP_BYTE_W-1:0] tx_cell_byte, // byte pins
	output logic tx_write_en_n, // write enable, active low
	output logic tx_start_of_cell // first-byte marker
);
	timeunit 1ns;
	timeprecision 100ps;
	initial begin
		tx_port_clk = 1'b0;
		tx_cell_byte = 8'h00;
		tx_write_en_n = 1'b1;
		tx_start_of_cell = 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// one 125 ns port cycle; pins settle in the low phase
	task automatic tick();
		#62.5 tx_port_clk = 1'b1;
		#62.5 tx_port_clk = 1'b0;
	endtask
	// n bytes counting up from seed, a dead cycle before byte gap;
	// pos is the place of the first byte within its cell
	task automatic write_bytes(input int n, input logic [7:0] seed, input int gap,
		input int pos);
		for (int i = 0; i < n; i++) begin
			if (i == gap) begin
				tx_write_en_n = 1'b1;
				tx_cell_byte = ~tx_cell_byte;
				tick();
			end
			tx_cell_byte = seed + 8'(i);
			tx_start_of_cell = ((pos + i) % ACTIP_CELL_BYTES) == 0;
			tx_write_en_n = 1'b0;
			tick();
		end
		tx_write_en_n = 1'b1;
		tx_start_of_cell = 1'b0;
		tx_cell_byte = ~tx_cell_byte; // released pins must not keep the last byte
	endtask
endmodule
`default_nettype wire

// File: test/actip_tx_port_test.sv
`default_nettype none
module actip_tx_port_test
	import actip_pkg::*;
();
	timeunit 1ns;
	timeprecision 100ps;
	logic clk_sys = 1'b0, rst_n = 1'b0, tx_dev_reset = 1'b0, out_ready = 1'b0;
	logic tx_port_clk, tx_write_en_n, tx_start_of_cell, tx_fifo_almost_full_n;
	logic out_soc, out_valid;
	logic [ACTIP_BYTE_W-1:0] tx_cell_byte, out_byte;
	logic [8:0] exp_q[$]; // marker and byte still owed on the mapper side
	int err_count = 0, compares = 0, pops = 0, cycles = 0;
	always #5 clk_sys = ~clk_sys; // 100 MHz
	actip_cell_writer w (.tx_port_clk(tx_port_clk), .tx_cell_byte(tx_cell_byte),
		.tx_write_en_n(tx_write_en_n), .tx_start_of_cell(tx_start_of_cell));
	actip_tx_port dut (.clk_sys(clk_sys), .rst_n(rst_n), .tx_port_clk(tx_port_clk),
		.tx_cell_byte(tx_cell_byte), .tx_write_en_n(tx_write_en_n),
		.tx_start_of_cell(tx_start_of_cell), .tx_dev_reset(tx_dev_reset),
		.tx_fifo_almost_full_n(tx_fifo_almost_full_n), .out_byte(out_byte),
		.out_soc(out_soc), .out_valid(out_valid), .out_ready(out_ready));
	////////////////////////////////////////////////////////////////
	task automatic check(input logic [8:0] got, input logic [8:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic flag_is(input logic e);
		check({8'h00, tx_fifo_almost_full_n}, {8'h00, e});
	endtask
	task automatic give_verdict();
		if (err_count == 0 && compares > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// every byte taken must be the next one written, in order
	always @(posedge clk_sys) begin
		if (out_valid === 1'b1 && out_ready === 1'b1) begin
			check({out_soc, out_byte}, exp_q.size() > 0 ? exp_q.pop_front() : 9'hxxx);
			pops++;
		end
	end
	// hang guard: the whole run needs well under 10000 cycles
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	////////////////////////////////////////////////////////////////
	// pos keeps cells whole across calls; no cell starts while the flag is low, the dead cycle after the flush raises it first
	task automatic send(input int n, input logic [7:0] seed, input int gap, input int pos);
		for (int i = 0; i < n; i++) begin
			exp_q.push_back({(pos + i) % ACTIP_CELL_BYTES == 0, seed + 8'(i)});
		end
		w.write_bytes(n, seed, gap, pos);
		repeat (8) @(posedge clk_sys); // lets the last edge cross the synchroniser
		#1;
	endtask
	// take exactly n bytes, then stall the mapper again
	task automatic drain(input int n);
		int target;
		target = pops + n;
		out_ready = 1'b1;
		for (int k = 0; k < 400 && pops < target; k++) begin
			@(posedge clk_sys);
			#1;
		end
		out_ready = 1'b0;
		check(9'(pops), 9'(target));
	endtask
	task automatic t_cell();
		send(53, 8'h10, 20, 0);
		drain(53);
		flag_is(1'b1);
	endtask
	// the mapper stage holds one byte beyond the store, so 155 bytes are
	// needed before the store itself has only five bytes of space left
	task automatic t_flag();
		send(154, 8'h40, 200, 0);
		flag_is(1'b1);
		send(1, 8'hda, 200, 48);
		flag_is(1'b0);
		drain(48);
		flag_is(1'b0);
		send(1, 8'hdb, 200, 49);
		flag_is(1'b0);
		drain(2);
		send(1, 8'hdc, 200, 50);
		flag_is(1'b1);
	endtask
	task automatic t_flush();
		send(48, 8'h80, 200, 51);
		flag_is(1'b0);
		tx_dev_reset = 1'b1;
		repeat (8) @(posedge clk_sys);
		#1 tx_dev_reset = 1'b0;
		exp_q.delete();
		repeat (4) @(posedge clk_sys);
		check({8'h00, out_valid}, 9'h000);
		flag_is(1'b0);
		send(1, 8'h5a, 0, 0);
		flag_is(1'b1);
		drain(1);
	endtask
	initial begin
		repeat (8) @(posedge clk_sys);
		#1 rst_n = 1'b1;
		check({7'h00, tx_fifo_almost_full_n, out_valid}, {7'h00, ACTIP_AF_N_RST, 1'b0});
		t_cell();
		t_flag();
		t_flush();
		give_verdict();
	end
endmodule
`default_nettype wire
